// ===== hw/sfw_wake_id.sv
// sleep entry, wake-up and device id read command handling
// assumes spi pins arrive asynchronously; wip and array port on mclk_in
`timescale 1ns/1ps
module sfw_wake_id
  import sfw_pkg::*;
#(
  parameter int POWERUP_CYC = POWERUP_READY_CYC,
  // identity code; value is arbitrary
  parameter logic [7:0] DEVICE_ID = 8'h5a
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire sfw_pins_t spi_pins_in,
  input wire logic write_in_progress_flag_in,
  input wire logic array_wr_in,
  input wire logic [ARRAY_AW-1:0] array_addr_in,
  input wire logic [7:0] array_wdata_in,
  output logic so_out,
  output logic so_oe_n_out,
  output sfw_cmd_t cmd_out,
  output logic asleep_out,
  output logic recovering_out,
  output logic ready_out,
  output logic [7:0] status_out,
  output logic [7:0] array_rdata_out
);
  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  sfw_pins_t pins_s1, pins_s2, pins_s3;
  sfw_frame_t state;
  logic [5:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_opcode;
  logic [2:0] id_idx;
  logic [15:0] rec_cnt;
  logic [15:0] pu_cnt;
  logic sclk_rise, sclk_fall, cs_rise, blocked, last_op_bit, wake_event;
  logic sleep_event;
  // idle pin levels, so that no false sclk edge follows reset
  localparam sfw_pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      pins_s1 <= PINS_IDLE;
      pins_s2 <= PINS_IDLE;
      pins_s3 <= PINS_IDLE;
    end else begin
      pins_s1 <= spi_pins_in;
      pins_s2 <= pins_s1;
      pins_s3 <= pins_s2;
    end
  end

  assign sclk_rise = rose(pins_s2.sclk, pins_s3.sclk) & ~pins_s2.cs_n;
  assign sclk_fall = rose(pins_s3.sclk, pins_s2.sclk) & ~pins_s2.cs_n;
  assign cs_rise = rose(pins_s2.cs_n, pins_s3.cs_n);
  assign blocked = recovering_out | ~ready_out;
  assign last_op_bit = sclk_rise && bit_cnt == OPCODE_BITS - 6'h01;
  assign next_opcode = {shift[6:0], pins_s2.si};

  // opcode and dummy bits are sampled on sclk rising edges
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in || pins_s2.cs_n) begin
      bit_cnt <= '0;
      shift <= '0;
    end else if (sclk_rise) begin
      shift <= next_opcode;
      if (bit_cnt != BIT_CNT_MAX) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in || pins_s2.cs_n) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          state <= blocked ? st_ignore : st_opcode;
        end
        st_opcode: begin
          if (last_op_bit) begin
            if (next_opcode == WAKE_ID_OP) begin
              state <= write_in_progress_flag_in ? st_ignore : st_dummy;
            end else if (next_opcode != SLEEP_OP) begin
              state <= st_ignore;
            end
          end else if (sclk_rise && bit_cnt >= OPCODE_BITS) begin
            state <= st_ignore;
          end
        end
        st_dummy: begin
          if (sclk_rise && bit_cnt == ID_START_BITS - 6'h01) begin
            state <= st_id_out;
          end
        end
        st_id_out: state <= st_id_out;
        st_ignore: state <= st_ignore;
      endcase
    end
  end

  // id bits leave on falling edges, msb first, wrapping to repeat the byte
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in || pins_s2.cs_n) begin
      so_out <= 1'b0;
      so_oe_n_out <= 1'b1;
      id_idx <= ID_MSB;
    end else if (state == st_id_out && sclk_fall) begin
      so_out <= DEVICE_ID[id_idx];
      so_oe_n_out <= 1'b0;
      id_idx <= id_idx - 3'h1;
    end
  end

  // other opcodes go on to the rest of the device; asleep only soft reset
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cmd_out <= '0;
    end else begin
      cmd_out.valid <= 1'b0;
      if (state == st_opcode && last_op_bit && next_opcode != WAKE_ID_OP
          && next_opcode != SLEEP_OP
          && (!asleep_out || next_opcode == SOFT_RESET_OP)) begin
        cmd_out.valid <= 1'b1;
        cmd_out.opcode <= next_opcode;
      end
    end
  end

  assign wake_event = cs_rise && asleep_out && !write_in_progress_flag_in
    && (state == st_dummy || state == st_id_out);
  assign sleep_event = cs_rise && !asleep_out && !write_in_progress_flag_in
    && state == st_opcode && bit_cnt == OPCODE_BITS
    && shift == SLEEP_OP;

  // an awake short ABH reaches neither branch and stays a no-op
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      asleep_out <= 1'b0;
    end else if (wake_event) begin
      asleep_out <= 1'b0;
    end else if (sleep_event) begin
      asleep_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      recovering_out <= 1'b0;
      rec_cnt <= '0;
    end else if (wake_event) begin
      recovering_out <= 1'b1;
      rec_cnt <= 16'(WAKEUP_RECOVERY_CYC - 1);
    end else if (rec_cnt != '0) begin
      rec_cnt <= rec_cnt - 16'h0001;
    end else begin
      recovering_out <= 1'b0;
    end
  end

  // commands are refused until the power-up ready delay has passed
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      ready_out <= 1'b0;
      pu_cnt <= '0;
    end else if (pu_cnt == 16'(POWERUP_CYC - 1)) begin
      ready_out <= 1'b1;
    end else begin
      pu_cnt <= pu_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      status_out <= STATUS_DELIVERED;
    end else begin
      status_out <= STATUS_DELIVERED;
      status_out[WIP_BIT] <= write_in_progress_flag_in;
    end
  end

  sfw_array u_array (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(array_wr_in),
    .addr_in(array_addr_in),
    .wdata_in(array_wdata_in),
    .rdata_out(array_rdata_out)
  );

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  a_wake_clears_sleep: assert property (wake_event |=> !asleep_out)
    else $error("wake opcode did not leave sleep");
  a_wake_starts_recov: assert property ($fell(asleep_out) |->
    recovering_out && rec_cnt == 16'(WAKEUP_RECOVERY_CYC - 1))
    else $error("recovery delay not started at wake");
  a_recov_ends_once: assert property (recovering_out && rec_cnt == '0
    |=> !recovering_out)
    else $error("recovery delay overran");
  a_recov_no_cmd: assert property (recovering_out |-> !cmd_out.valid)
    else $error("command passed during recovery");
  a_id_on_fall: assert property (!so_oe_n_out && $changed(so_out)
    |-> $past(sclk_fall))
    else $error("id bit changed off a falling edge");
  a_release_on_cs: assert property (cs_rise |=> so_oe_n_out)
    else $error("output still driven after cs high");
  a_wip_ignores_id: assert property (state == st_opcode && last_op_bit
    && next_opcode == WAKE_ID_OP && write_in_progress_flag_in
    |=> state == st_ignore)
    else $error("id opcode taken during write cycle");
  a_status_delivered: assert property ($rose(reset_n_in)
    |-> status_out == STATUS_DELIVERED)
    else $error("status not delivered value");
  a_asleep_filter: assert property (asleep_out && cmd_out.valid
    |-> cmd_out.opcode == SOFT_RESET_OP)
    else $error("command passed while asleep");
  a_sleep_cause: assert property ($rose(asleep_out)
    |-> $past(sleep_event))
    else $error("sleep entered without exact sleep opcode");
  a_partial_dropped: assert property (cs_rise && bit_cnt < OPCODE_BITS
    |=> $stable(asleep_out) && !cmd_out.valid)
    else $error("partial opcode had an effect");
  a_powerup_hold: assert property (!ready_out |-> !cmd_out.valid)
    else $error("command before power-up delay");

  c_sleep_entry: cover property (sleep_event);
  c_wake_only: cover property (wake_event && state == st_dummy);
  c_id_repeat: cover property (state == st_id_out && sclk_fall
    && id_idx == ID_MSB && !so_oe_n_out);
  c_recov_done: cover property ($fell(recovering_out));
endmodule

// ===== include/sfw_pkg.sv
// constants, carriers and frame states for the sleep-wake and id-read block
// assumes a 25 MHz system clock and an spi host on the far side of the pins
package sfw_pkg;
  localparam logic [7:0] WAKE_ID_OP = 8'hab;
  localparam logic [7:0] SLEEP_OP = 8'hb9;
  // software reset opcode; value is a plain default
  localparam logic [7:0] SOFT_RESET_OP = 8'hff;
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  // opcode plus three dummy bytes
  localparam logic [5:0] ID_START_BITS = 6'h20;
  localparam logic [5:0] BIT_CNT_MAX = 6'h3f;
  localparam logic [2:0] ID_MSB = 3'h7;
  localparam logic [7:0] ARRAY_ERASED = 8'hff;
  localparam logic [7:0] STATUS_DELIVERED = 8'h00;
  localparam int WIP_BIT = 0;
  localparam int ARRAY_DEPTH = 16;
  localparam int ARRAY_AW = 4;
  localparam int MCLK_KHZ = 25000;
  localparam int POWERUP_READY_MS = 1;
  localparam int POWERUP_READY_CYC = POWERUP_READY_MS * MCLK_KHZ;
  localparam int WAKEUP_RECOVERY_NS = 3000;
  localparam int WAKEUP_RECOVERY_CYC =
    (WAKEUP_RECOVERY_NS * MCLK_KHZ + 999999) / 1000000;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } sfw_pins_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } sfw_cmd_t;

  typedef enum logic [2:0] {
    st_idle,
    st_opcode,
    st_dummy,
    st_id_out,
    st_ignore
  } sfw_frame_t;
endpackage

// ===== hw/sfw_array.sv
// small storage array with registered read data, erased at reset
// assumes same-clock write and read requests from the owning block
`timescale 1ns/1ps
module sfw_array
  import sfw_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic wr_en_in,
  input wire logic [ARRAY_AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [ARRAY_DEPTH];

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < ARRAY_DEPTH; i++) begin
        mem[i] <= ARRAY_ERASED;
      end
    end else if (wr_en_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      rdata_out <= ARRAY_ERASED;
    end else begin
      rdata_out <= mem[addr_in];
    end
  end
endmodule

// ===== verif/sfw_host_model.sv
// spi host model: frames bits on the pins and collects so on each clock
// assumes the bench calls xfer just after a falling mclk edge
`timescale 1ns/1ps
module sfw_host_model
  import sfw_pkg::*;
(
  input wire logic so_in,
  output sfw_pins_t pins_out
);
  logic [15:0] rx;
  initial pins_out = 3'b100;
  // n bits of d msb first, x more clocks, then cs rises; sclk idles low
  task automatic xfer(input logic [31:0] d, input int n, input int x);
    pins_out.cs_n = 1'b0;
    for (int i = 0; i < n + x; i++) begin
      pins_out.si = (i < n) ? d[n-1-i] : ~pins_out.si;
      #160 pins_out.sclk = 1'b1;
      #150 rx = {rx[14:0], so_in};
      #10 pins_out.sclk = 1'b0;
    end
    #160 pins_out.cs_n = 1'b1;
    // released data line must not keep its last value
    pins_out.si = ~pins_out.si;
  endtask
endmodule

// ===== verif/sfw_wake_id_tb.sv
// bench for sleep entry, wake-up and id read through the host model
// assumes a 25 MHz mclk; the host model makes a 320 ns sclk
`timescale 1ns/1ps
module sfw_wake_id_tb;
  import sfw_pkg::*;
  localparam logic [7:0] ID = 8'h5a;
  logic mclk_in = 0;
  logic reset_n_in = 0;
  logic write_in_progress_flag = 0;
  logic wr = 0;
  logic [3:0] addr = 0;
  logic [7:0] wd = 0;
  logic [7:0] status, rdata;
  logic so, oe_n, asleep, rec, rdy;
  int cmd_cnt = 0;
  int oe_cnt = 0;
  int rec_cnt = 0;
  int cmd_base = 0;
  int oe_base = 0;
  int rec_base = 0;
  sfw_pins_t pins;
  sfw_cmd_t cmd;
  int fails = 0;
  int samples_checked = 0;
  always #20 mclk_in = ~mclk_in;
  // a released so line shows the inverse of its last bit
  sfw_host_model host_u (.so_in(oe_n ? ~so : so), .pins_out(pins));
  sfw_wake_id #(.POWERUP_CYC(20), .DEVICE_ID(ID)) dut_u (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .spi_pins_in(pins),
    .write_in_progress_flag_in(write_in_progress_flag), .array_wr_in(wr),
    .array_addr_in(addr), .array_wdata_in(wd), .so_out(so),
    .so_oe_n_out(oe_n), .cmd_out(cmd), .asleep_out(asleep),
    .recovering_out(rec), .ready_out(rdy), .status_out(status),
    .array_rdata_out(rdata));
  always @(posedge mclk_in) begin
    if (cmd.valid === 1'b1) cmd_cnt <= cmd_cnt + 1;
    if (oe_n === 1'b0) oe_cnt <= oe_cnt + 1;
    if (rec === 1'b1) rec_cnt <= rec_cnt + 1;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic send(input logic [31:0] d, input int n, input int x);
    cyc(1);
    cmd_base = cmd_cnt;
    oe_base = oe_cnt;
    rec_base = rec_cnt;
    cyc(1);
    host_u.xfer(d, n, x);
    cyc(6);
  endtask
  task automatic t_reset();
    chk(16'(rdy), 16'h0000);
    chk(16'(status), 16'h0000);
    // a frame before the power-up delay ends must be ignored
    send(32'h0000_0003, 8, 0);
    chk(16'(cmd_cnt - cmd_base), 16'h0000);
    for (int a = 0; a < ARRAY_DEPTH; a++) begin
      addr <= a[3:0];
      cyc(2);
      chk(16'(rdata), 16'h00ff);
    end
    chk(16'(rdy), 16'h0001);
    wr <= 1'b1;
    addr <= 4'h3;
    wd <= 8'h3c;
    cyc(1);
    wr <= 1'b0;
    cyc(2);
    chk(16'(rdata), 16'h003c);
  endtask
  task automatic t_id();
    send(32'hab00_0000, 32, 16);
    chk(host_u.rx, {ID, ID});
    chk(16'(oe_n), 16'h0001);
    chk(16'(asleep), 16'h0000);
  endtask
  task automatic t_refused();
    send(32'h0000_0172, 9, 0);
    chk(16'(asleep), 16'h0000);
    send(32'h0000_0015, 5, 0);
    chk(16'(cmd_cnt - cmd_base), 16'h0000);
    write_in_progress_flag <= 1'b1;
    send(32'h0000_00b9, 8, 0);
    chk(16'(asleep), 16'h0000);
    chk(16'(status), 16'h0001);
    send(32'hab00_0000, 32, 8);
    chk(16'(oe_cnt - oe_base), 16'h0000);
    write_in_progress_flag <= 1'b0;
  endtask
  task automatic t_sleep_wake();
    send(32'h0000_00b9, 8, 0);
    chk(16'(asleep), 16'h0001);
    send(32'h0000_0003, 8, 0);
    chk(16'(cmd_cnt - cmd_base), 16'h0000);
    chk(16'(asleep), 16'h0001);
    send(32'h0000_00ff, 8, 0);
    chk(16'(cmd_cnt - cmd_base), 16'h0001);
    chk(16'(cmd.opcode), 16'(SOFT_RESET_OP));
    chk(16'(asleep), 16'h0001);
    send(32'h0000_00ab, 8, 0);
    chk(16'(asleep), 16'h0000);
    chk(16'(rec), 16'h0001);
    cyc(80);
    chk(16'(rec_cnt - rec_base), 16'(WAKEUP_RECOVERY_CYC));
    send(32'h0000_0003, 8, 0);
    chk(16'(cmd_cnt - cmd_base), 16'h0001);
    chk(16'(cmd.opcode), 16'h0003);
    send(32'h0000_00ab, 8, 0);
    chk(16'(rec), 16'h0000);
  endtask
  task automatic t_id_asleep();
    send(32'h0000_00b9, 8, 0);
    chk(16'(asleep), 16'h0001);
    send(32'hab00_0000, 32, 8);
    chk(16'(host_u.rx[7:0]), 16'(ID));
    chk(16'(asleep), 16'h0000);
    // a command inside the recovery delay must be refused
    send(32'h0000_0003, 8, 0);
    chk(16'(cmd_cnt - cmd_base), 16'h0000);
    cyc(80);
    chk(16'(rec), 16'h0000);
  endtask
  initial begin
    cyc(10);
    reset_n_in <= 1'b1;
    cyc(1);
    t_reset();
    t_id();
    t_refused();
    t_sleep_wake();
    t_id_asleep();
    end_sim();
  end
  initial begin
    #1000000;
    fails++;
    end_sim();
  end
endmodule
